//--- arf_pkg.sv
// Purpose: Shared constants and types for the converter result formatter
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: Offsets are byte addresses
package arf_pkg;
    localparam logic [7:0] OFF_INPUT_SELECT = 8'h00;
    localparam logic [7:0] OFF_RESULT_LOW = 8'h04;
    localparam logic [7:0] OFF_RESULT_HIGH = 8'h08;
    localparam logic [7:0] OFF_CONTROL = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_ACTIVE_CFG = 8'h18;
    localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
    localparam int REF_MSB = 7;
    localparam int REF_LSB = 6;
    localparam int LEFT_ALIGN_BIT = 5;
    localparam int CHAN_MSB = 4;
    localparam int CTRL_BUSY_BIT = 0;
    localparam int CTRL_DONE_BIT = 1;
    localparam int IRQ_DONE_BIT = 0;
    localparam logic [1:0] REF_EXTERNAL = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_RESERVED = 2'h2;
    localparam logic [1:0] REF_INTERNAL = 2'h3;
    localparam logic [4:0] CHAN_SINGLE_LAST = 5'h07;
    localparam logic [4:0] CHAN_BANDGAP = 5'h1E;
    localparam logic [4:0] CHAN_GROUND = 5'h1F;
    localparam logic [9:0] SE_MIN_CODE = 10'h000;
    localparam logic [9:0] SE_MAX_CODE = 10'h3FF;
    localparam logic [9:0] DIFF_MOST_NEG = 10'h200;
    localparam logic [9:0] DIFF_MOST_POS = 10'h1FF;
    localparam logic [9:0] DIFF_MINUS_ONE = 10'h3FF;
    localparam int SIGN_BIT = 9;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] reference_select;
        logic left_align_result;
        logic [4:0] channel_gain_select;
    } arf_input_select_type;

    // Analog core handshake toward this block
    typedef struct packed {
        logic start;
        logic done;
        logic differential;
        logic [9:0] code;
    } arf_core_event_type;

    typedef enum logic [1:0] {
        ARF_IDLE = 2'b01,
        ARF_BUSY = 2'b10
    } arf_state_type;
endpackage

//--- arf_result_format.sv
// Purpose: Input selection register and result formatting for a 10-bit converter
// Assumes: Analog core reports start, done, differential and a 10-bit code
// Notes: Registers over AXI4-Lite; one level interrupt on conversion done
// Behaviour
// (R1) After completion, the result appears through the low and high result registers.
// (R2) Single-ended results are unsigned 10-bit codes, 0x000 ground to 0x3FF top.
// (R3) Differential results are 10-bit two's complement, 0x200 to 0x1FF.
// (R4) Bit 9 of a differential result is the sign, one meaning negative.
// (R5) Positive full scale gives 0x1FF, zero gives zero, just below zero 0x3FF.
// (R6) Input select register: ref 7:6, left align 5, channel 4:0, reset zero.
// (R7) Reference codes: external pin, analog supply, reserved, internal 2.56V.
// (R8) Reference change during a conversion waits until that conversion completes.
// (R9) Left-align one gives left-adjusted result, zero gives right-adjusted.
// (R10) Alignment change affects the result view at once, even mid-conversion.
// (R11) Software should not toggle converter pins used as outputs while converting.
// (R12) Same pin on both differential inputs converts the residual offset.
// (R13) Right: high 1:0 = bits 9:8; left: high = 9:2, low 7:6 = 1:0.
// (R14) Channel codes 0-7 single-ended, 11110 bandgap, 11111 ground, others differential.
// (R15) Completion flag sets when the result registers hold the new value.
// (R16) Raw result kept; both views derived from it on read.
`timescale 1ns/1ns
module arf_result_format
    import arf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire arf_pkg::arf_core_event_type core_event,
    output arf_pkg::arf_input_select_type active_select_q,
    output logic irq_q
);
    import arf_pkg::*;

    arf_input_select_type input_select_q;
    arf_state_type state_q;
    logic [9:0] raw_result_q;
    logic done_flag_q;
    logic irq_status_q;
    logic irq_mask_q;
    logic [7:0] aw_addr_q;
    logic aw_have_q;
    logic [31:0] w_data_q;
    logic w_strb0_q;
    logic w_have_q;
    logic wr_fire;
    logic wr_clear_done;
    logic [7:0] result_low;
    logic [7:0] result_high;
    logic [31:0] rd_data;
    logic rd_ok;

    // Write address and data are accepted independently, one of each at a time;
    // readies are flops, low from the take until the response is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    assign wr_fire = aw_have_q & w_have_q;
    assign wr_clear_done = wr_fire & w_strb0_q & (aw_addr_q == OFF_IRQ_STATUS) & w_data_q[IRQ_DONE_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb0_q <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q == OFF_INPUT_SELECT || aw_addr_q == OFF_IRQ_STATUS ||
                            aw_addr_q == OFF_IRQ_MASK) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // All eight bits writable; reference values are not checked, reserved code is stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            input_select_q <= INPUT_SELECT_RESET; // R6
        end else if (wr_fire && w_strb0_q && aw_addr_q == OFF_INPUT_SELECT) begin
            input_select_q <= w_data_q[7:0]; // R6 R7 R14
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= 1'b0;
        end else if (wr_fire && w_strb0_q && aw_addr_q == OFF_IRQ_MASK) begin
            irq_mask_q <= w_data_q[IRQ_DONE_BIT];
        end
    end

    // Selection the analog core uses; frozen while converting, so a mid-conversion
    // write to reference or channel lands only at completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ARF_IDLE;
            active_select_q <= INPUT_SELECT_RESET;
        end else begin
            unique case (state_q)
                ARF_IDLE: begin
                    active_select_q <= input_select_q;
                    if (core_event.start) begin
                        state_q <= ARF_BUSY;
                    end
                end
                ARF_BUSY: begin
                    if (core_event.done) begin
                        state_q <= ARF_IDLE;
                        active_select_q <= input_select_q; // R8
                    end
                end
            endcase
        end
    end

    // Raw code stored as delivered: unsigned single-ended, two's complement
    // differential; equal-pin pairs yield the offset code unchanged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            raw_result_q <= SE_MIN_CODE;
        end else if (state_q == ARF_BUSY && core_event.done) begin
            raw_result_q <= core_event.code; // R1 R2 R3 R4 R5 R12 R16
        end
    end

    // Flag rises with the same edge that loads the result; set beats clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_flag_q <= 1'b0;
            irq_status_q <= 1'b0;
        end else begin
            if (state_q == ARF_BUSY && core_event.done) begin
                done_flag_q <= 1'b1; // R15
                irq_status_q <= 1'b1;
            end else if (wr_clear_done) begin
                done_flag_q <= 1'b0;
                irq_status_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_status_q & irq_mask_q;
        end
    end

    // Views follow the live align bit, not the frozen copy
    always_comb begin
        if (input_select_q.left_align_result) begin
            result_high = raw_result_q[9:2]; // R9 R10 R13
            result_low = {raw_result_q[1:0], 6'h00}; // R13
        end else begin
            result_high = {6'h00, raw_result_q[9:8]}; // R9 R13
            result_low = raw_result_q[7:0]; // R13
        end
    end

    always_comb begin
        rd_ok = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (s_axi_araddr)
            OFF_INPUT_SELECT: rd_data = {24'h00_0000, input_select_q};
            OFF_RESULT_LOW: rd_data = {24'h00_0000, result_low}; // R1
            OFF_RESULT_HIGH: rd_data = {24'h00_0000, result_high}; // R1
            OFF_CONTROL: rd_data = {30'h0000_0000, done_flag_q, state_q == ARF_BUSY};
            OFF_IRQ_STATUS: rd_data = {31'h0000_0000, irq_status_q};
            OFF_IRQ_MASK: rd_data = {31'h0000_0000, irq_mask_q};
            OFF_ACTIVE_CFG: rd_data = {24'h00_0000, active_select_q};
            default: rd_ok = 1'b0;
        endcase
    end

    // One read in flight; ready returns when the answer is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_ref_held_busy: assert property (@(posedge clk) disable iff (rst) // R8
        (state_q == ARF_BUSY && !core_event.done) |=>
        active_select_q.reference_select == $past(active_select_q.reference_select))
        else $error("reference changed during a conversion");

    a_select_follows: assert property (@(posedge clk) disable iff (rst) // R8
        state_q == ARF_IDLE |=> active_select_q == $past(input_select_q))
        else $error("selection not tracking while idle");

    a_done_loads: assert property (@(posedge clk) disable iff (rst) // R15
        (state_q == ARF_BUSY && core_event.done) |=>
        done_flag_q && raw_result_q == $past(core_event.code))
        else $error("flag or result not loaded on completion");

    a_flag_clear: assert property (@(posedge clk) disable iff (rst) // R15
        (wr_clear_done && !(state_q == ARF_BUSY && core_event.done)) |=> !done_flag_q && !irq_status_q)
        else $error("write one did not clear the flag");

    a_right_view: assert property (@(posedge clk) disable iff (rst) // R13
        !input_select_q.left_align_result |->
        result_high == {6'h00, raw_result_q[9:8]} && result_low == raw_result_q[7:0])
        else $error("right adjusted view wrong");

    a_left_view: assert property (@(posedge clk) disable iff (rst) // R4 R13
        input_select_q.left_align_result |->
        result_high == raw_result_q[9:2] && result_high[7] == raw_result_q[SIGN_BIT] &&
        result_low == {raw_result_q[1:0], 6'h00})
        else $error("left adjusted view wrong");

    a_select_reset: assert property (@(posedge clk) // R6
        $fell(rst) |-> input_select_q == INPUT_SELECT_RESET)
        else $error("select register not zero after reset");

    a_write_refused: assert property (@(posedge clk) disable iff (rst)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while a response is pending");

    a_set_wins: assert property (@(posedge clk) disable iff (rst)
        (state_q == ARF_BUSY && core_event.done && wr_clear_done) |=> irq_status_q)
        else $error("clear beat completion event");

    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        (irq_status_q && irq_mask_q) |=> irq_q)
        else $error("interrupt did not follow status");

    a_read_answer: assert property (@(posedge clk) disable iff (rst) // R1
        (s_axi_arvalid && s_axi_arready) |=>
        s_axi_rvalid && s_axi_rresp == ($past(rd_ok) ? AXI_OKAY : AXI_SLVERR))
        else $error("read answer missing");
endmodule

//--- arf_core_model.sv
// Purpose: Analog core stand-in that reports conversion start, done and code
// Assumes: One conversion at a time, done comes hold cycles after start
// Notes: Code bus toggles outside done so a stale value never matches
`timescale 1ns/1ns
module arf_core_model
    import arf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic diff,
    input wire logic [9:0] code,
    input wire logic [7:0] hold,
    output arf_pkg::arf_core_event_type core_event,
    output logic busy
);
    import arf_pkg::*;

    logic [7:0] cnt_q;
    logic [9:0] code_q;
    logic diff_q;
    assign busy = cnt_q != 8'h00;
    // Inputs latched at go, so pin changes while converting do not affect the conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
            code_q <= 10'h000;
            diff_q <= 1'b0;
            core_event <= '0;
        end else begin
            core_event.start <= go && !busy;
            core_event.done <= cnt_q == 8'h01;
            core_event.differential <= diff_q;
            core_event.code <= (cnt_q == 8'h01) ? code_q : ~core_event.code;
            if (go && !busy) begin
                cnt_q <= hold;
                code_q <= code;
                diff_q <= diff;
            end else if (busy) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

//--- adc_result_format_and_ref_select_tb.sv
// Purpose: Self-checking bench for the result formatter
// Assumes: AXI4-Lite master tasks, core model as conversion source
// Notes: Waits on handshakes; watchdog ends any hang
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module adc_result_format_and_ref_select_tb;
    import arf_pkg::*;
    logic clk, rst, awv, wv, bready, arv, rready, go, diff, busy, irq_q;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] awaddr, araddr, hold;
    logic [31:0] wdata, rdata, rv;
    logic [9:0] code;
    arf_input_select_type active_select_q;
    arf_core_event_type core_event;
    int err_count, compares;
    logic [4:0] ch_tab [9] = '{5'h00, 5'h07, 5'h1E, 5'h1F, 5'h08, 5'h0D, 5'h10, 5'h19, 5'h1A};
    logic [9:0] cd_tab [9] = '{10'h3FF, 10'h000, 10'h155, 10'h000, 10'h001, 10'h1FF, 10'h000, 10'h3FF, 10'h200};
    arf_result_format dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_event(core_event),
        .active_select_q(active_select_q), .irq_q(irq_q));
    arf_core_model core (.clk(clk), .rst(rst), .go(go), .diff(diff), .code(code), .hold(hold),
        .core_event(core_event), .busy(busy));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk);
            ta = ta || awready;
            tw = tw || wready;
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic wait_conv;
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task automatic conv(input logic [9:0] c, input logic d, input logic [7:0] h, input logic w);
        @(posedge clk);
        go <= 1'b1;
        code <= c;
        diff <= d;
        hold <= h;
        @(posedge clk);
        go <= 1'b0;
        if (w) wait_conv();
    endtask
    task automatic t_format;
        rd(OFF_INPUT_SELECT);
        `CHK("sel reset", 32'h0000_0000, rv)
        rd(OFF_RESULT_HIGH);
        `CHK("high reset", 32'h0000_0000, rv)
        wr(OFF_INPUT_SELECT, 32'h0000_00ED);
        `CHK("bresp ok", AXI_OKAY, rs)
        rd(OFF_INPUT_SELECT);
        `CHK("sel", 32'h0000_00ED, rv)
        `CHK("rresp ok", AXI_OKAY, rs)
        conv(10'h270, 1'b1, 8'h05, 1'b1);
        rd(OFF_CONTROL);
        `CHK("done", 1'b1, rv[CTRL_DONE_BIT])
        rd(OFF_RESULT_LOW);
        `CHK("low left", 32'h0000_0000, rv)
        rd(OFF_RESULT_HIGH);
        `CHK("high left", 32'h0000_009C, rv)
        wr(OFF_INPUT_SELECT, 32'h0000_00CD);
        rd(OFF_RESULT_LOW);
        `CHK("low right", 32'h0000_0070, rv)
        rd(OFF_RESULT_HIGH);
        `CHK("high right", 32'h0000_0002, rv)
        $display("format test done");
    endtask
    task automatic t_codes;
        for (int i = 0; i < 9; i++) begin
            wr(OFF_INPUT_SELECT, {27'h0, ch_tab[i]});
            conv(cd_tab[i], ch_tab[i] > CHAN_SINGLE_LAST && ch_tab[i] < CHAN_BANDGAP, 8'h03, 1'b1);
            rd(OFF_ACTIVE_CFG);
            `CHK("active", {27'h0, ch_tab[i]}, rv)
            rd(OFF_RESULT_LOW);
            `CHK("low", {24'h0, cd_tab[i][7:0]}, rv)
            rd(OFF_RESULT_HIGH);
            `CHK("high", {30'h0, cd_tab[i][9:8]}, rv)
            `CHK("sign", cd_tab[i][SIGN_BIT], rv[1])
        end
        $display("code test done");
    endtask
    task automatic t_defer;
        for (int r = 0; r < 4; r++) begin
            wr(OFF_INPUT_SELECT, {24'h0, 2'(r), 6'h0D});
            rd(OFF_INPUT_SELECT);
            `CHK("ref", {24'h0, 2'(r), 6'h0D}, rv)
        end
        wr(OFF_INPUT_SELECT, 32'h0000_00E0);
        conv(10'h155, 1'b0, 8'h30, 1'b0);
        wr(OFF_INPUT_SELECT, 32'h0000_0040);
        `CHK("frozen", 8'hE0, active_select_q)
        rd(OFF_RESULT_HIGH);
        `CHK("live align", 32'h0000_0002, rv)
        wait_conv();
        `CHK("updated", 8'h40, active_select_q)
        rd(OFF_RESULT_HIGH);
        `CHK("new high", 32'h0000_0001, rv)
        $display("defer test done");
    endtask
    task automatic t_irq;
        wr(OFF_IRQ_STATUS, 32'h0000_0001);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk);
        `CHK("irq clear", 1'b0, irq_q)
        conv(10'h001, 1'b0, 8'h03, 1'b1);
        repeat (2) @(posedge clk);
        `CHK("irq set", 1'b1, irq_q)
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, irq_q)
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk);
        `CHK("irq unmasked", 1'b1, irq_q)
        wr(OFF_IRQ_STATUS, 32'h0000_0001);
        repeat (2) @(posedge clk);
        `CHK("irq w1c", 1'b0, irq_q)
        rd(OFF_CONTROL);
        `CHK("done clr", 1'b0, rv[CTRL_DONE_BIT])
        wr(8'h1C, 32'h0000_0001);
        `CHK("bresp", AXI_SLVERR, rs)
        rd(8'h1C);
        `CHK("rresp", AXI_SLVERR, rs)
        // Two-cycle conversion: its completion lands on the same edge as the clearing write
        conv(10'h2AA, 1'b0, 8'h02, 1'b0);
        wr(OFF_IRQ_STATUS, 32'h0000_0001);
        rd(OFF_IRQ_STATUS);
        `CHK("set wins", 1'b1, rv[IRQ_DONE_BIT])
        $display("irq test done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
    initial begin
        {rst, awv, wv, bready, arv, rready, go, diff} = 8'hFF & 8'h80;
        {awaddr, araddr, hold, wdata, code} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_format();
        t_codes();
        t_defer();
        t_irq();
        stop_test();
    end
endmodule
